// ---- ioc_consts.svh ----
// constants for the i/o port configuration block
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH
// ==========================================
// register indices (byte address is index times four)
`define IOC_IDX_P0_MODE    8'h8f
`define IOC_IDX_P2_SEL     8'hf5
`define IOC_IDX_P1_MODE    8'hf6
`define IOC_IDX_P2_MODE    8'hf7
`define IOC_IDX_P0_DIR     8'hfd
`define IOC_IDX_P1_DIR     8'hfe
`define IOC_IDX_P2_DIR     8'hff
`define IOC_IDX_LSB        2
`define IOC_IDX_MSB        9
// ==========================================
// field positions
`define IOC_SEL_SER_PAIR   6
`define IOC_SEL_SER1_TMR3  5
`define IOC_SEL_TMR1_TMR4  4
`define IOC_SEL_SER0_TMR1  3
`define IOC_SEL_PIN24      2
`define IOC_SEL_PIN23      1
`define IOC_SEL_PIN20      0
`define IOC_DIR_PREC_MSB   7
`define IOC_DIR_PREC_LSB   6
`define IOC_PULL_DIR_P0    5
`define IOC_PULL_DIR_P1    6
`define IOC_PULL_DIR_P2    7
// ==========================================
// masks, reset values, encodings
`define IOC_SEL_MASK       8'h7f
`define IOC_PORT2_DIRECTION_MASK     8'hdf
`define IOC_P1MODE_MASK    8'hfc
`define IOC_P2_PIN_MASK    8'h1f
`define IOC_RESET_VAL      8'h00
`define IOC_PREC_S0_S1     2'h0
`define IOC_PREC_S1_S0     2'h1
`define IOC_PREC_T1_S1     2'h2
`define IOC_RESP_OKAY      2'h0
`define IOC_RESP_SLVERR    2'h2
`endif

// ---- ioc_pkg.sv ----
// types shared by the i/o port configuration block
package ioc_pkg;
  // ==========================================
  // peripheral request toward one 8-pin port
  typedef struct packed {
    logic [7:0] claim;
    logic [7:0] dout;
    logic [7:0] doe;
  } ioc_periph_type;
  // ==========================================
  // pad control toward one 8-pin port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull_en;
    logic [7:0] pull_down;
  } ioc_pad_type;
endpackage

// ---- ioc_port_config.sv ----
// i/o port direction, function select, precedence and input mode
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ioc_consts.svh"
// Behaviour
// - same-pin serial units: bit 6 low gives serial zero, high gives serial one
// - serial one versus timer three: bit 5 low serial one, high timer three
// - timer one versus timer four: bit 4 low timer one, high timer four
// - serial zero versus timer one: bit 3 low serial zero, high timer one
// - bits 2,1,0 pick gpio or peripheral for third-port pins 4,3,0
// - first-port direction bit: 0 input, 1 output, resets to inputs
// - second-port direction bit: 0 input, 1 output, resets to zero
// - third-port direction bits 4:0 set pins 4..0; bit 5 reads zero
// - bits 7:6 of third direction order first-port peripheral precedence
// - first-port mode bit: 0 pull, 1 tristate, resets to zero
// - second-port mode only bits 7:2; bits 1:0 read zero, no control
// - one bit per port chooses pull-up (0) or pull-down (1)
// - active debug overrides third-port pins 1 and 2 select and direction
// - oscillator select low puts third-port pins 3,4 analog, overriding settings
module ioc_port_config
  import ioc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic           clk_sys,
  input  wire logic           reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic [7:0]     first_port_function_sel,
  input  wire logic [7:0]     second_port_function_sel,
  input  wire logic [7:0]     gpio_dout0,
  input  wire logic [7:0]     gpio_dout1,
  input  wire logic [7:0]     gpio_dout2,
  input  wire ioc_periph_type p0_serial0,
  input  wire ioc_periph_type p0_serial1,
  input  wire ioc_periph_type p0_timer1,
  input  wire ioc_periph_type p1_serial0,
  input  wire ioc_periph_type p1_serial1,
  input  wire ioc_periph_type p1_timer1,
  input  wire ioc_periph_type p1_timer3,
  input  wire ioc_periph_type p1_timer4,
  input  wire ioc_periph_type p2_periph,
  input  wire logic           debug_active,
  input  wire logic           debug_data_out,
  input  wire logic           debug_data_oe,
  input  wire logic           low_freq_osc_select,
  output ioc_pad_type         pad0,
  output ioc_pad_type         pad1,
  output ioc_pad_type         pad2,
  output logic [7:0]          pad2_analog
);

  // ==========================================
  // elaboration check
  generate
    if (ADDR_W < `IOC_IDX_MSB + 1) begin : g_bad_addr
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  // ==========================================
  // registers
  logic [7:0] first_port_input_mode_reg;
  logic [7:0] third_port_function_select_reg;
  logic [7:0] second_port_input_mode_reg;
  logic [7:0] third_port_input_mode_reg;
  logic [7:0] first_port_direction_reg;
  logic [7:0] second_port_direction_reg;
  logic [7:0] third_port_direction_reg;

  logic              aw_held_reg;
  logic [7:0]        aw_idx_reg;
  logic              aw_hi_reg;
  logic              w_held_reg;
  logic [7:0]        w_data_reg;
  logic              w_lane_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic              do_write;
  logic              wr_hit;
  logic [7:0]        rd_idx;
  logic              rd_hi;
  logic [7:0]        rd_val;
  logic              rd_hit;

  // ==========================================
  // axi4-lite handshakes
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;

  always_comb begin
    case (aw_idx_reg)
      `IOC_IDX_P0_MODE, `IOC_IDX_P2_SEL, `IOC_IDX_P1_MODE, `IOC_IDX_P2_MODE,
      `IOC_IDX_P0_DIR, `IOC_IDX_P1_DIR, `IOC_IDX_P2_DIR: wr_hit = !aw_hi_reg;
      default: wr_hit = 1'b0;
    endcase
  end

  // write address and data may arrive in either order
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= `IOC_RESET_VAL;
      aw_hi_reg   <= 1'b0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= `IOC_RESET_VAL;
      w_lane_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[`IOC_IDX_MSB:`IOC_IDX_LSB];
        aw_hi_reg   <= |(s_axi_awaddr >> (`IOC_IDX_MSB + 1));
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `IOC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `IOC_RESP_OKAY : `IOC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register file; reserved bits are masked on write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_port_input_mode_reg      <= `IOC_RESET_VAL;
      third_port_function_select_reg <= `IOC_RESET_VAL;
      second_port_input_mode_reg     <= `IOC_RESET_VAL;
      third_port_input_mode_reg      <= `IOC_RESET_VAL;
      first_port_direction_reg       <= `IOC_RESET_VAL;
      second_port_direction_reg      <= `IOC_RESET_VAL;
      third_port_direction_reg       <= `IOC_RESET_VAL;
    end else if (do_write && w_lane_reg && !aw_hi_reg) begin
      case (aw_idx_reg)
        `IOC_IDX_P0_MODE: first_port_input_mode_reg <= w_data_reg;
        `IOC_IDX_P2_SEL:  third_port_function_select_reg <= w_data_reg & `IOC_SEL_MASK;
        `IOC_IDX_P1_MODE: second_port_input_mode_reg <= w_data_reg & `IOC_P1MODE_MASK;
        `IOC_IDX_P2_MODE: third_port_input_mode_reg <= w_data_reg;
        `IOC_IDX_P0_DIR:  first_port_direction_reg <= w_data_reg;
        `IOC_IDX_P1_DIR:  second_port_direction_reg <= w_data_reg;
        `IOC_IDX_P2_DIR:  third_port_direction_reg <= w_data_reg & `IOC_PORT2_DIRECTION_MASK;
        default: ;
      endcase
    end
  end

  // read decode
  assign rd_idx = s_axi_araddr[`IOC_IDX_MSB:`IOC_IDX_LSB];
  assign rd_hi  = |(s_axi_araddr >> (`IOC_IDX_MSB + 1));

  always_comb begin
    rd_hit = !rd_hi;
    case (rd_idx)
      `IOC_IDX_P0_MODE: rd_val = first_port_input_mode_reg;
      `IOC_IDX_P2_SEL:  rd_val = third_port_function_select_reg;
      `IOC_IDX_P1_MODE: rd_val = second_port_input_mode_reg;
      `IOC_IDX_P2_MODE: rd_val = third_port_input_mode_reg;
      `IOC_IDX_P0_DIR:  rd_val = first_port_direction_reg;
      `IOC_IDX_P1_DIR:  rd_val = second_port_direction_reg;
      `IOC_IDX_P2_DIR:  rd_val = third_port_direction_reg;
      default: begin
        rd_val = `IOC_RESET_VAL;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `IOC_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? `IOC_RESP_OKAY : `IOC_RESP_SLVERR;
      rdata_reg  <= {24'h000000, rd_hit ? rd_val : `IOC_RESET_VAL};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================
  // precedence helpers
  // port 0 pick: 0 serial zero, 1 serial one, 2 timer one, 3 none
  function automatic logic [1:0] pick_p0(input logic [2:0] c, input logic [1:0] prec);
    logic [1:0] o0;
    logic [1:0] o1;
    logic [1:0] o2;
    case (prec)
      `IOC_PREC_S0_S1: begin o0 = 2'h0; o1 = 2'h1; o2 = 2'h2; end
      `IOC_PREC_S1_S0: begin o0 = 2'h1; o1 = 2'h0; o2 = 2'h2; end
      `IOC_PREC_T1_S1: begin o0 = 2'h2; o1 = 2'h1; o2 = 2'h0; end
      default:         begin o0 = 2'h2; o1 = 2'h0; o2 = 2'h1; end
    endcase
    if (c[o0])      pick_p0 = o0;
    else if (c[o1]) pick_p0 = o1;
    else if (c[o2]) pick_p0 = o2;
    else            pick_p0 = 2'h3;
  endfunction

  // port 1 pick: 0 s0, 1 s1, 2 t1, 3 t3, 4 t4, 7 none
  function automatic logic [2:0] pick_p1(input logic [4:0] c, input logic [7:0] sel);
    logic [4:0] lose;
    lose[0] = (c[1] && sel[`IOC_SEL_SER_PAIR]) || (c[2] && sel[`IOC_SEL_SER0_TMR1]);
    lose[1] = (c[0] && !sel[`IOC_SEL_SER_PAIR]) || (c[3] && sel[`IOC_SEL_SER1_TMR3]);
    lose[2] = (c[0] && !sel[`IOC_SEL_SER0_TMR1]) || (c[4] && sel[`IOC_SEL_TMR1_TMR4]);
    lose[3] = c[1] && !sel[`IOC_SEL_SER1_TMR3];
    lose[4] = c[2] && !sel[`IOC_SEL_TMR1_TMR4];
    pick_p1 = 3'h7;
    for (int k = 4; k >= 0; k--) begin
      if (c[k] && !lose[k]) pick_p1 = 3'(k);
    end
    if (pick_p1 == 3'h7) begin
      for (int k = 4; k >= 0; k--) begin
        if (c[k]) pick_p1 = 3'(k);
      end
    end
  endfunction

  // ==========================================
  // per-pin pad control
  ioc_pad_type pad0_next;
  ioc_pad_type pad1_next;
  ioc_pad_type pad2_next;
  logic [7:0]  analog_next;
  logic [7:0]  p2_sel;
  logic [7:0]  p1_pull_ctl;
  localparam logic [7:0] P2_PINS = `IOC_P2_PIN_MASK;

  // third-port select bits sit on pins 4, 3 and 0
  assign p2_sel = {3'h0, third_port_function_select_reg[`IOC_SEL_PIN24],
                   third_port_function_select_reg[`IOC_SEL_PIN23], 2'h0,
                   third_port_function_select_reg[`IOC_SEL_PIN20]};
  // pins 1:0 of the second port have no mode control and keep their pull
  assign p1_pull_ctl = second_port_input_mode_reg & `IOC_P1MODE_MASK;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      logic [1:0] w0;
      logic [2:0] w1;
      logic [3:0][1:0] v0;
      logic [7:0][1:0] v1;
      logic       o2;
      logic       e2;
      logic       an;
      always_comb begin
        // first port
        w0 = pick_p0({p0_timer1.claim[i], p0_serial1.claim[i], p0_serial0.claim[i]},
                     third_port_direction_reg[`IOC_DIR_PREC_MSB:`IOC_DIR_PREC_LSB]);
        v0 = {2'h0, p0_timer1.doe[i], p0_timer1.dout[i], p0_serial1.doe[i],
              p0_serial1.dout[i], p0_serial0.doe[i], p0_serial0.dout[i]};
        if (!first_port_function_sel[i]) begin
          pad0_next.dout[i] = gpio_dout0[i];
          pad0_next.oe[i]   = first_port_direction_reg[i];
        end else begin
          {pad0_next.oe[i], pad0_next.dout[i]} = v0[w0];
        end
        pad0_next.pull_en[i]   = !pad0_next.oe[i] && !first_port_input_mode_reg[i];
        pad0_next.pull_down[i] = third_port_input_mode_reg[`IOC_PULL_DIR_P0];
        // second port
        w1 = pick_p1({p1_timer4.claim[i], p1_timer3.claim[i], p1_timer1.claim[i],
                      p1_serial1.claim[i], p1_serial0.claim[i]},
                     third_port_function_select_reg);
        v1 = {6'h00, p1_timer4.doe[i], p1_timer4.dout[i], p1_timer3.doe[i], p1_timer3.dout[i],
              p1_timer1.doe[i], p1_timer1.dout[i], p1_serial1.doe[i], p1_serial1.dout[i],
              p1_serial0.doe[i], p1_serial0.dout[i]};
        if (!second_port_function_sel[i]) begin
          pad1_next.dout[i] = gpio_dout1[i];
          pad1_next.oe[i]   = second_port_direction_reg[i];
        end else begin
          {pad1_next.oe[i], pad1_next.dout[i]} = v1[w1];
        end
        pad1_next.pull_en[i]   = !pad1_next.oe[i] && !p1_pull_ctl[i];
        pad1_next.pull_down[i] = third_port_input_mode_reg[`IOC_PULL_DIR_P1];
        // third port
        an = 1'b0;
        if (p2_sel[i] && p2_periph.claim[i]) begin
          o2 = p2_periph.dout[i];
          e2 = p2_periph.doe[i];
        end else begin
          o2 = gpio_dout2[i];
          e2 = third_port_direction_reg[i] && !p2_sel[i];
        end
        if (debug_active && (i == 1)) begin
          o2 = debug_data_out;
          e2 = debug_data_oe;
        end else if (debug_active && (i == 2)) begin
          o2 = 1'b0;
          e2 = 1'b0;
        end
        if (!low_freq_osc_select && (i == 3 || i == 4)) begin
          o2 = 1'b0;
          e2 = 1'b0;
          an = 1'b1;
        end
        pad2_next.dout[i]      = o2 && P2_PINS[i];
        pad2_next.oe[i]        = e2 && P2_PINS[i];
        pad2_next.pull_en[i]   = P2_PINS[i] && !e2 && !an &&
                                 !third_port_input_mode_reg[i];
        pad2_next.pull_down[i] = P2_PINS[i] &&
                                 third_port_input_mode_reg[`IOC_PULL_DIR_P2];
        analog_next[i]         = an;
      end
    end
  endgenerate

  // registered pad outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pad0        <= '0;
      pad1        <= '0;
      pad2        <= '0;
      pad2_analog <= '0;
    end else begin
      pad0        <= pad0_next;
      pad1        <= pad1_next;
      pad2        <= pad2_next;
      pad2_analog <= analog_next;
    end
  end

endmodule

// ---- ioc_periph_model.sv ----
// peripheral side model feeding the port configuration block
`timescale 1ns/1ps
module ioc_periph_model
  import ioc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [8:0] active,
  output ioc_periph_type  periph [9]
);
  // ==========================================
  // released lines toggle every cycle
  logic [7:0] idle_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idle_reg <= 8'h5a;
    end else begin
      idle_reg <= ~idle_reg;
    end
  end
  // ==========================================
  // claiming units drive a fixed pattern per unit
  always_comb begin
    for (int k = 0; k < 9; k++) begin
      periph[k].claim = active[k] ? 8'hff : 8'h00;
      periph[k].dout  = active[k] ? 8'(8'h11 * (k + 1)) : idle_reg;
      periph[k].doe   = active[k] ? 8'hff : idle_reg;
    end
  end
endmodule

// ---- ioc_port_config_sva.sv ----
// assertions on the port configuration block's ports
`timescale 1ns/1ps
module ioc_port_config_sva
  import ioc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        debug_active,
  input wire logic        debug_data_out,
  input wire logic        debug_data_oe,
  input wire logic        low_freq_osc_select,
  input wire ioc_pad_type pad0,
  input wire ioc_pad_type pad1,
  input wire ioc_pad_type pad2,
  input wire logic [7:0]  pad2_analog
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // bus timing
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response timing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // ==========================================
  // pad relations
  osc_own_a: assert property (!low_freq_osc_select |=> pad2_analog[4:3] == 2'b11 &&
    pad2.oe[4:3] == 2'b00 && pad2.pull_en[4:3] == 2'b00) else $error("oscillator pins not taken");
  osc_free_a: assert property (low_freq_osc_select |=> pad2_analog[4:3] == 2'b00)
    else $error("oscillator pins analog");
  dbg_pin_a: assert property (debug_active |=> pad2.oe[2:1] == {1'b0, $past(debug_data_oe)} &&
    (!pad2.oe[1] || pad2.dout[1] == $past(debug_data_out))) else $error("debug pins wrong");
  pull_drive_a: assert property ($past(reset_n) |->
    (pad0.oe & pad0.pull_en) == 8'h00 && (pad1.oe & pad1.pull_en) == 8'h00) else $error("pull on driven pin");
  low_pull_a: assert property ($past(reset_n) |-> pad1.pull_en[1:0] == ~pad1.oe[1:0])
    else $error("second port low pins pull");
  p2_high_a: assert property (pad2.oe[7:5] == 3'b000 && pad2_analog[7:5] == 3'b000)
    else $error("third port high pins active");
endmodule
bind ioc_port_config ioc_port_config_sva #(.ADDR_W(ADDR_W)) chk (.*);

// ---- ioc_testbench.sv ----
// self-checking bench for the port configuration block
`timescale 1ns/1ps
`include "ioc_consts.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t mismatch %h exp %h", $time, a, e); end end
module testbench
  import ioc_pkg::*;
;
  typedef struct {int port; logic [7:0] oe, dout, pull; logic pd;} ioc_exp_type;
  localparam logic [11:0] RA [7] = '{12'h23c, 12'h3d4, 12'h3d8, 12'h3dc, 12'h3f4, 12'h3f8, 12'h3fc};
  localparam logic [7:0] RM [7] = '{8'hff, 8'h7f, 8'hfc, 8'hff, 8'hff, 8'hff, 8'hdf};
  localparam logic [31:0] PT [12] = '{32'h1000_1803, 32'h1400_1804, 32'h1000_5004, 32'h1200_5006,
    32'h1000_a005, 32'h1100_a007, 32'h1000_2803, 32'h1080_2805, 32'h0000_0300, 32'h0400_0301,
    32'h0800_0602, 32'h0c00_0502};
  logic clk_sys, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic debug_active, debug_data_out, debug_data_oe, low_freq_osc_select;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] first_port_function_sel, second_port_function_sel, gpio_dout0, gpio_dout1, gpio_dout2;
  logic [7:0] pad2_analog, d0, d1, m0, g0, g1, pv, pw;
  logic [11:0] pa;
  logic [3:0] pt;
  logic [2:0] pd;
  logic [8:0] active;
  ioc_pad_type pad0, pad1, pad2, p;
  ioc_periph_type periph [9];
  ioc_exp_type pq [$], e;
  logic [9:0] rq [$], rx;
  logic [1:0] bq [$], bx;
  int errors = 0, checked = 0;
  event pad_ev;
  ioc_periph_model model (.clk_sys, .reset_n, .active, .periph);
  ioc_port_config dut (.*, .p0_serial0(periph[0]), .p0_serial1(periph[1]), .p0_timer1(periph[2]),
    .p1_serial0(periph[3]), .p1_serial1(periph[4]), .p1_timer1(periph[5]), .p1_timer3(periph[6]),
    .p1_timer4(periph[7]), .p2_periph(periph[8]));
  // ==========================================
  // clock, watchdog, result monitor
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    final_report();
  end
  always @(negedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rx = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, {rx[9:8], 24'h0, rx[7:0]})
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bx = bq.pop_front();
      `CHK(s_axi_bresp, bx)
    end
  end
  always @(pad_ev) begin
    e = pq.pop_front();
    p = e.port == 0 ? pad0 : e.port == 1 ? pad1 : pad2;
    `CHK({p.oe, p.dout & p.oe, p.pull_en, p.pull_down & p.pull_en},
         {e.oe, e.dout & e.oe, e.pull, e.pull & {8{e.pd}}})
  end
  // ==========================================
  // bus and pad tasks
  task automatic await(input bit is_rd);
    do @(negedge clk_sys); while (!(is_rd ? s_axi_rvalid : s_axi_bvalid));
    @(posedge clk_sys);
    if (is_rd) s_axi_rready <= 1'b1; else s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    if (is_rd) s_axi_rready <= 1'b0; else s_axi_bready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic a_d = 1'b0, w_d = 1'b0, a_t, w_t;
    bq.push_back(r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a_d && w_d)) begin
      @(negedge clk_sys);
      a_t = s_axi_awready;
      w_t = s_axi_wready;
      @(posedge clk_sys);
      if (a_t) begin s_axi_awvalid <= 1'b0; a_d = 1'b1; end
      if (w_t) begin s_axi_wvalid <= 1'b0; w_d = 1'b1; end
    end
    await(1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [9:0] x);
    rq.push_back(x);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    await(1'b1);
  endtask
  task automatic pad_chk(input ioc_exp_type x);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    pq.push_back(x);
    -> pad_ev;
    @(posedge clk_sys);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {debug_active, debug_data_out, debug_data_oe, reset_n} = '0;
    low_freq_osc_select = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, active} = '0;
    s_axi_wstrb = 4'hf;
    {first_port_function_sel, second_port_function_sel, gpio_dout0, gpio_dout1, gpio_dout2} = '0;
    void'($urandom(32'h78cfdad5));
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(RA[i], {`IOC_RESP_OKAY, `IOC_RESET_VAL});
      wr(RA[i], 8'hff, `IOC_RESP_OKAY);
      rd(RA[i], {`IOC_RESP_OKAY, RM[i]});
      wr(RA[i], 8'h00, `IOC_RESP_OKAY);
    end
    wr(12'h000, 8'hff, `IOC_RESP_SLVERR);
    rd(12'h7f4, {`IOC_RESP_SLVERR, 8'h00});
    s_axi_wstrb <= 4'h0;
    wr(RA[4], 8'h5a, `IOC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(RA[4], {`IOC_RESP_OKAY, `IOC_RESET_VAL});
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      {d0, d1, m0, g0} = $urandom;
      {g1, pd} = 11'($urandom);
      gpio_dout0 <= g0;
      gpio_dout1 <= g1;
      gpio_dout2 <= d0;
      wr(RA[4], d0, `IOC_RESP_OKAY);
      wr(RA[5], d1, `IOC_RESP_OKAY);
      wr(RA[0], m0, `IOC_RESP_OKAY);
      wr(RA[2], 8'hff, `IOC_RESP_OKAY);
      wr(RA[3], {pd, 5'h00}, `IOC_RESP_OKAY);
      pad_chk('{0, d0, g0, ~d0 & ~m0, pd[0]});
      pad_chk('{1, d1, g1, ~d1 & 8'h03, pd[1]});
    end
    $display("test gpio done");
    first_port_function_sel <= 8'hff;
    second_port_function_sel <= 8'hff;
    foreach (PT[i]) begin
      {pt, pv, pa, pw} = PT[i];
      active <= pa[8:0];
      wr(pt[0] ? RA[1] : RA[6], pv, `IOC_RESP_OKAY);
      pw = 8'h11 * (pw + 8'h01);
      pad_chk('{pt, 8'hff, pw, 8'h00, 1'b0});
    end
    $display("test precedence done");
    first_port_function_sel <= 8'h00;
    second_port_function_sel <= 8'h00;
    active <= 9'h100;
    wr(RA[3], 8'h00, `IOC_RESP_OKAY);
    wr(RA[6], 8'h00, `IOC_RESP_OKAY);
    wr(RA[1], 8'h07, `IOC_RESP_OKAY);
    pad_chk('{2, 8'h19, 8'h99, 8'h06, 1'b0});
    low_freq_osc_select <= 1'b0;
    pad_chk('{2, 8'h01, 8'h99, 8'h06, 1'b0});
    {debug_active, debug_data_oe, debug_data_out} <= 3'b111;
    pad_chk('{2, 8'h03, 8'h03, 8'h04, 1'b0});
    repeat (40) @(posedge clk_sys) begin
      {debug_active, debug_data_oe, debug_data_out, low_freq_osc_select} <= 4'($urandom);
    end
    $display("test third port done");
    final_report();
  end
endmodule
